// *** rtl/ep0_ctrl.sv ***
// Endpoint-zero control-transfer sequencer with bus-reset recovery
`timescale 1ns/1ps
`include "ep0_ctrl_map.svh"
module ep0_ctrl
#(
	parameter int MAX_PKT = 8,
	parameter int RECOVER_CYCLES = `RST_DONE_MS * `CLK_KHZ
)
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rd_data_o,
	input wire logic usb_reset_i,
	input wire ep0_ctrl_pkg::tok_t tok_i,
	input wire logic [63:0] setup_data_i,
	output ep0_ctrl_pkg::hs_t hs_o,
	output ep0_ctrl_pkg::tx_req_t tx_req_o,
	output ep0_ctrl_pkg::ctl_t ctl_o,
	output logic [6:0] dev_addr_o,
	output logic ep0_enable_o,
	output logic power_mgmt_irq_o
);
	import ep0_ctrl_pkg::*;

	localparam logic [15:0] MPS = 16'(MAX_PKT);
	st_t r;
	st_t n;
	logic live;
	logic dir_in;
	logic [15:0] wlen;
	logic [15:0] chunk;
	function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
		umin = (a < b) ? a : b;
	endfunction
	assign live = r.ep_en && (r.rs == RS_RUN);
	assign dir_in = r.setup[`SU_DIR];
	assign wlen = r.setup[`SU_LEN];
	assign chunk = umin(r.remain, MPS);

	always_comb
	begin
		n = r;
		n.hs = HS_NONE;
		n.tx = '0;
		n.ctl = '0;
		n.rdata = '0;
		n.rst_prev = usb_reset_i;

		// Reset recovery sequence
		unique case (r.rs)
			RS_RUN: ;
			RS_CLEAR:
			begin
				n.addr = '0;
				n.addr_pend = 1'b0;
				n.ep_en = 1'b0;
				n.ctl.dma_rst = 1'b1;
				n.ctl.pmm_rst = 1'b1;
				n.cs = CS_IDLE;
				n.rx_stall = 1'b0;
				n.tx_stall = 1'b0;
				n.tx_pend = 1'b0;
				n.rs = RS_WAIT;
			end
			RS_WAIT:
				if (!usb_reset_i)
					n.rs = RS_SIE;
			RS_SIE:
			begin
				n.ctl.sie_rst = 1'b1;
				n.ep_en = 1'b1;
				n.rs = RS_RUN;
			end
		endcase
		// Register writes
		if (wr_i)
		begin
			if (addr_i == `REG_STATUS && wr_data_i[`ST_FLAG])
				n.rst_flag = 1'b0;
			if (addr_i == `REG_CTRL)
			begin
				n.wake_en = wr_data_i[`CTRL_WAKE];
				n.irq_mask = wr_data_i[`CTRL_MASK];
				n.app_busy = wr_data_i[`CTRL_BUSY];
			end
		end
		// Software verdict on the held Setup packet
		if (live && r.cs == CS_SETUP && wr_i && addr_i == `REG_DECIDE)
		begin
			if (dir_in)
			begin
				if (wr_data_i[`DEC_ACCEPT])
				begin
					n.remain = umin(wr_data_i[`DEC_LEN], wlen);
					n.more = 1'b1;
					n.tx_tog = 1'b1;
					n.cs = CS_RD_DATA;
				end
				else
				begin
					n.rx_stall = 1'b1;
					n.tx.go = 1'b1;
					n.tx.pid1 = 1'b1;
					n.tx_tog = 1'b1;
					n.tx_pend = 1'b1;
					n.cs = CS_IDLE;
				end
			end
			else if (wlen != 16'h0000)
			begin
				if (wr_data_i[`DEC_ACCEPT])
					n.cs = CS_WR_DATA;
				else
				begin
					n.rx_stall = 1'b1;
					n.cs = CS_IDLE;
				end
			end
			else if (wr_data_i[`DEC_ACCEPT])
			begin
				if (r.setup[`SU_TYPE] == `TYPE_STD && r.setup[`SU_REQ] == `REQ_SET_ADDR)
				begin
					n.new_addr = r.setup[`SU_NEW_ADDR];
					n.addr_pend = 1'b1;
				end
				n.more = 1'b1;
				n.cs = CS_WR_STATUS;
			end
			else
			begin
				n.rx_stall = 1'b1;
				n.tx_stall = 1'b1;
				n.cs = CS_IDLE;
			end
		end
		// Queue the next packet of a read, or the status packet
		if (live && !tok_i.setup && !r.tx_pend && r.more)
		begin
			if (r.cs == CS_RD_DATA)
			begin
				n.tx.go = 1'b1;
				n.tx.len = chunk[6:0];
				n.tx.pid1 = r.tx_tog;
				n.tx_pend = 1'b1;
				n.remain = r.remain - chunk;
				n.more = (chunk == MPS);
			end
			else if (r.cs == CS_WR_STATUS)
			begin
				n.tx.go = 1'b1;
				n.tx.pid1 = 1'b1;
				n.tx_tog = 1'b1;
				n.tx_pend = 1'b1;
				n.more = 1'b0;
			end
		end
		// Token handling
		if (live)
		begin
			if (tok_i.setup)
			begin
				n.ctl.flush = r.tx_pend;
				n.tx_pend = 1'b0;
				n.rx_stall = 1'b0;
				n.tx_stall = 1'b0;
				n.more = 1'b0;
				n.addr_pend = 1'b0;
				n.cs = CS_IDLE;
				if (!r.rx_stall && !r.app_busy)
				begin
					n.hs = HS_ACK;
					n.setup = setup_data_i;
					n.ctl.release_buf = 1'b1;
					n.rx_tog = 1'b1;
					n.cs = CS_SETUP;
				end
				// Unanswered Setup is simply dropped for a retry
			end
			else if (tok_i.in)
			begin
				if (r.tx_stall)
					n.hs = HS_STALL;
				else if (r.tx_pend)
					n.hs = HS_DATA;
				else
					n.hs = HS_NAK;
			end
			else if (tok_i.in_ack && r.tx_pend)
			begin
				n.tx_pend = 1'b0;
				n.tx_tog = ~r.tx_tog;
				if (r.cs == CS_WR_STATUS)
				begin
					if (r.addr_pend)
						n.addr = r.new_addr;
					n.addr_pend = 1'b0;
					n.cs = CS_IDLE;
				end
			end
			else if (tok_i.out)
			begin
				if (r.rx_stall)
					n.hs = HS_STALL;
				else if (r.cs == CS_RD_DATA)
				begin
					n.hs = HS_ACK;
					n.ctl.flush = r.tx_pend;
					n.tx_pend = 1'b0;
					n.more = 1'b0;
					n.cs = CS_IDLE;
				end
				else if (r.cs == CS_WR_DATA)
				begin
					if (r.app_busy)
						n.hs = HS_NAK;
					else
					begin
						n.hs = HS_ACK;
						if (tok_i.rx_tog == r.rx_tog)
						begin
							n.ctl.out_take = 1'b1;
							n.rx_tog = ~r.rx_tog;
							if (16'(tok_i.len) < MPS)
							begin
								n.more = 1'b1;
								n.cs = CS_WR_STATUS;
							end
						end
					end
				end
				else
					n.hs = HS_NAK;
			end
		end
		// A new bus reset wins over any clear and restarts recovery
		if (usb_reset_i && !r.rst_prev)
		begin
			n.rst_flag = 1'b1;
			n.rs = RS_CLEAR;
		end
		if (rd_i)
		begin
			unique case (addr_i)
				`REG_STATUS:
				begin
					n.rdata[`ST_FLAG] = r.rst_flag;
					n.rdata[`ST_BUSY] = (r.rs != RS_RUN);
					n.rdata[`ST_SEQ] = r.cs;
				end
				`REG_CTRL:
				begin
					n.rdata[`CTRL_WAKE] = r.wake_en;
					n.rdata[`CTRL_MASK] = r.irq_mask;
					n.rdata[`CTRL_BUSY] = r.app_busy;
				end
				`REG_ADDR: n.rdata[`ADDR_FIELD] = r.addr;
				`REG_SETUP_LO: n.rdata = r.setup[31:0];
				`REG_SETUP_HI: n.rdata = r.setup[63:32];
				default: n.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			r <= '0;
			r.rs <= RS_RUN;
			r.cs <= CS_IDLE;
		end
		else
			r <= n;
	end

	assign rd_data_o = r.rdata;
	assign hs_o = r.hs;
	assign tx_req_o = r.tx;
	assign ctl_o = r.ctl;
	assign dev_addr_o = r.addr;
	assign ep0_enable_o = r.ep_en;
	assign power_mgmt_irq_o = r.rst_flag && r.wake_en && r.irq_mask;

	// Cycles since the bus reset ended while recovery still runs
	int unsigned rec_cnt;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rec_cnt <= 0;
		else if (usb_reset_i || r.rs == RS_RUN)
			rec_cnt <= 0;
		else
			rec_cnt <= rec_cnt + 1;
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_flag_set: assert property ($rose(usb_reset_i) |=> r.rst_flag)
		else $error("bus reset flag not set");
	a_irq_gate: assert property ($rose(usb_reset_i) && r.wake_en && r.irq_mask && !wr_i
		|=> power_mgmt_irq_o)
		else $error("reset interrupt missing");
	a_clear_order: assert property ($rose(usb_reset_i) |=> ##1 ctl_o.dma_rst && ctl_o.pmm_rst
		&& dev_addr_o == 7'h00 && !ep0_enable_o)
		else $error("reset clear step wrong");
	a_engine_hold: assert property (ctl_o.sie_rst |-> !$past(usb_reset_i) && !$past(usb_reset_i, 2))
		else $error("engine reset during bus reset");
	a_recover_time: assert property (rec_cnt < RECOVER_CYCLES)
		else $error("reset recovery too slow");
	a_read_cap: assert property (live && r.cs == CS_SETUP && wr_i && addr_i == `REG_DECIDE && dir_in
		&& wr_data_i[`DEC_ACCEPT] && !tok_i.setup |=> r.remain <= wlen && r.tx_tog)
		else $error("read length not capped");
	a_busy_nak: assert property (live && tok_i.in && !r.tx_pend && !r.tx_stall && !$rose(usb_reset_i)
		|=> hs_o == HS_NAK)
		else $error("idle IN not NAKed");
	a_status_ack: assert property (live && tok_i.out && r.cs == CS_RD_DATA && !r.rx_stall
		&& !$rose(usb_reset_i) |=> hs_o == HS_ACK && r.cs == CS_IDLE && !r.tx_pend)
		else $error("read status not closed");
	a_addr_hold: assert property ($changed(dev_addr_o) && dev_addr_o != 7'h00
		|-> $past(tok_i.in_ack) && $past(r.cs) == CS_WR_STATUS)
		else $error("address switched early");
	a_setup_idle: assert property (live && tok_i.setup && !$rose(usb_reset_i)
		|=> (r.cs == CS_IDLE || r.cs == CS_SETUP) && !r.rx_stall && !r.tx_stall && !r.tx_pend)
		else $error("setup left stale state");
	a_stall_setup: assert property (live && tok_i.setup && r.rx_stall |=> hs_o == HS_NONE)
		else $error("stalled setup answered");
	a_toggle_flip: assert property (live && tok_i.in_ack && r.tx_pend && !tok_i.setup
		&& !$rose(usb_reset_i) |=> r.tx_tog != $past(r.tx_tog))
		else $error("transmit toggle not flipped");

	c_read_done: cover property (r.cs == CS_RD_DATA ##[1:300] r.cs == CS_IDLE);
	c_write_status: cover property (r.cs == CS_WR_DATA ##[1:300] r.cs == CS_WR_STATUS);
	c_addr_set: cover property ($changed(dev_addr_o) && dev_addr_o != 7'h00);
	c_reset_done: cover property (ctl_o.sie_rst);
endmodule

// *** rtl/ep0_ctrl_map.svh ***
// Register offsets, field positions and timing figures of the endpoint-zero controller
`ifndef EP0_CTRL_MAP_SVH
`define EP0_CTRL_MAP_SVH
`define REG_STATUS 8'h00
`define REG_CTRL 8'h04
`define REG_DECIDE 8'h08
`define REG_ADDR 8'h0c
`define REG_SETUP_LO 8'h10
`define REG_SETUP_HI 8'h14
`define ST_FLAG 0
`define ST_BUSY 1
`define ST_SEQ 6:2
`define CTRL_WAKE 0
`define CTRL_MASK 1
`define CTRL_BUSY 2
`define DEC_ACCEPT 16
`define DEC_LEN 15:0
`define ADDR_FIELD 6:0
`define SU_DIR 7
`define SU_TYPE 6:5
`define SU_REQ 15:8
`define SU_NEW_ADDR 22:16
`define SU_LEN 63:48
`define TYPE_STD 2'h0
`define REQ_SET_ADDR 8'h05
`define RST_DONE_MS 10
`define CLK_KHZ 20000
`endif

// *** rtl/ep0_ctrl_pkg.sv ***
// Types shared by the endpoint-zero controller and its users
package ep0_ctrl_pkg;
	typedef enum logic [3:0] {RS_RUN = 4'h1, RS_CLEAR = 4'h2, RS_WAIT = 4'h4, RS_SIE = 4'h8} rst_seq_t;
	typedef enum logic [4:0] {CS_IDLE = 5'h01, CS_SETUP = 5'h02, CS_RD_DATA = 5'h04, CS_WR_DATA = 5'h08,
		CS_WR_STATUS = 5'h10} ctl_seq_t;
	typedef enum logic [2:0] {HS_NONE = 3'h0, HS_ACK = 3'h1, HS_NAK = 3'h2, HS_STALL = 3'h3,
		HS_DATA = 3'h4} hs_t;
	typedef struct packed {
		logic setup;
		logic out;
		logic in;
		logic in_ack;
		logic rx_tog;
		logic [6:0] len;
	} tok_t;
	typedef struct packed {
		logic go;
		logic pid1;
		logic [6:0] len;
	} tx_req_t;
	typedef struct packed {
		logic dma_rst;
		logic pmm_rst;
		logic sie_rst;
		logic release_buf;
		logic flush;
		logic out_take;
	} ctl_t;
	typedef struct packed {
		rst_seq_t rs;
		ctl_seq_t cs;
		logic rst_prev;
		logic rst_flag;
		logic wake_en;
		logic irq_mask;
		logic app_busy;
		logic ep_en;
		logic [6:0] addr;
		logic [6:0] new_addr;
		logic addr_pend;
		logic [63:0] setup;
		logic rx_stall;
		logic tx_stall;
		logic tx_tog;
		logic rx_tog;
		logic tx_pend;
		logic [15:0] remain;
		logic more;
		hs_t hs;
		tx_req_t tx;
		ctl_t ctl;
		logic [31:0] rdata;
	} st_t;
endpackage

// *** bench/usb_host_model.sv ***
// Host model that issues bus resets and endpoint-zero tokens
`timescale 1ns/1ps
module usb_host_model
(
	input wire logic ref_clk_i,
	output ep0_ctrl_pkg::tok_t tok_o,
	output logic [63:0] setup_data_o,
	output logic usb_reset_o
);
	import ep0_ctrl_pkg::*;
	initial
	begin
		tok_o = '0;
		setup_data_o = 64'h0;
		usb_reset_o = 1'b0;
	end
	// Caller holds the level for the scaled minimum
	task automatic set_reset(input logic v);
		@(posedge ref_clk_i);
		usb_reset_o <= v;
	endtask
	task automatic send(input int k, input logic [6:0] len, input logic tog, input logic [63:0] s);
		tok_t t;
		t = '0;
		t.len = len;
		t.rx_tog = tog;
		t.setup = (k == 0);
		t.out = (k == 1);
		t.in = (k == 2);
		t.in_ack = (k == 3);
		@(posedge ref_clk_i);
		tok_o <= t;
		setup_data_o <= s;
		@(posedge ref_clk_i);
		tok_o <= '0;
		// Setup bytes mean nothing without the strobe
		setup_data_o <= ~s;
	endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the endpoint-zero controller
`timescale 1ns/1ps
module testbench;
	import ep0_ctrl_pkg::*;
	localparam int MAX_PKT = 8;
	localparam int HOLD = 64;
	logic ref_clk_i;
	logic sys_rst_i;
	logic [7:0] addr_i;
	logic [31:0] wr_data_i;
	logic wr_i;
	logic rd_i;
	logic [31:0] rd_data_o;
	logic usb_reset_i;
	tok_t tok_i;
	logic [63:0] setup_data_i;
	hs_t hs_o;
	tx_req_t tx_req_o;
	ctl_t ctl_o;
	logic [6:0] dev_addr_o;
	logic ep0_enable_o;
	logic power_mgmt_irq_o;
	int err_count = 0;
	int tests_run = 0;
	int cycles = 0;
	hs_t hsq[$];
	logic [31:0] rdq[$];
	logic rd_seen = 1'b0;
	logic [31:0] lfsr;
	ep0_ctrl #(.MAX_PKT(MAX_PKT), .RECOVER_CYCLES(64)) uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.usb_reset_i(usb_reset_i), .tok_i(tok_i), .setup_data_i(setup_data_i), .hs_o(hs_o),
		.tx_req_o(tx_req_o), .ctl_o(ctl_o), .dev_addr_o(dev_addr_o), .ep0_enable_o(ep0_enable_o),
		.power_mgmt_irq_o(power_mgmt_irq_o));
	usb_host_model host (.ref_clk_i(ref_clk_i), .tok_o(tok_i), .setup_data_o(setup_data_i),
		.usb_reset_o(usb_reset_i));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [63:0] su(input logic [7:0] b0, input logic [7:0] rq, input logic [15:0] v,
		input logic [15:0] l);
		return {l, 16'h0, v, rq, b0};
	endfunction
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		rdq.push_back(e);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
	endtask
	// Expected answer is noted before the token goes out
	task automatic tk(input int k, input logic [6:0] len, input logic tog, input logic [63:0] s, input hs_t e);
		if (e != HS_NONE)
			hsq.push_back(e);
		host.send(k, len, tog, s);
	endtask
	task automatic wait_go(input logic pid, input logic [6:0] len);
		for (int k = 0; k < 40; k++)
		begin
			@(posedge ref_clk_i);
			if (tx_req_o.go === 1'b1)
				break;
		end
		chk("queued packet", {23'h0, 1'b1, pid, len}, {23'h0, tx_req_o});
	endtask
	always @(posedge ref_clk_i)
	begin
		if (rd_seen && rdq.size() > 0)
			chk("read data", rdq.pop_front(), rd_data_o);
		rd_seen = rd_i;
		if (hs_o !== HS_NONE)
			chk("handshake", (hsq.size() > 0) ? 32'(hsq.pop_front()) : 32'hff, 32'(hs_o));
		cycles++;
		if (cycles == 6000)
		begin
			err_count++;
			give_verdict();
		end
	end
	initial
	begin
		hs_t ans[3];
		logic [7:0] b0s[3];
		logic [15:0] wl;
		logic [15:0] item;
		int n;
		int len;
		logic pid;
		ans = '{HS_DATA, HS_NAK, HS_STALL};
		b0s = '{8'h80, 8'h40, 8'h00};
		sys_rst_i = 1'b1;
		addr_i = 8'h00;
		wr_data_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		lfsr = 32'h171d562c;
		repeat (8) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		reg_wr(8'h04, 32'h1);
		host.set_reset(1'b1);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("reset pulses", 10'h300, {ctl_o.dma_rst, ctl_o.pmm_rst, ep0_enable_o, dev_addr_o});
		chk("irq masked", 0, power_mgmt_irq_o);
		reg_wr(8'h04, 32'h3);
		#1;
		chk("irq", 1, power_mgmt_irq_o);
		repeat (HOLD) @(posedge ref_clk_i);
		chk("early", 0, {ctl_o.sie_rst, ep0_enable_o});
		host.set_reset(1'b0);
		@(posedge ref_clk_i);
		#1;
		chk("enable", 0, ep0_enable_o);
		@(posedge ref_clk_i);
		#1;
		chk("recovery", 2'b11, {ctl_o.sie_rst, ep0_enable_o});
		reg_rd(8'h00, 32'h5);
		reg_wr(8'h00, 32'h1);
		#1;
		chk("irq clear", 0, power_mgmt_irq_o);
		reg_rd(8'h00, 32'h4);
		reg_rd(8'h20, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			lfsr = lfsr_next(lfsr);
			wl = {11'h0, lfsr[4:0]};
			item = {11'h0, lfsr[12:8]};
			n = (item < wl) ? item : wl;
			tk(0, 0, 0, su(8'h80, 8'h06, 16'h0100, wl), HS_ACK);
			reg_wr(8'h08, {15'h0, 1'b1, item});
			pid = 1'b1;
			for (int p = 0; p < 8; p++)
			begin
				len = (n > MAX_PKT) ? MAX_PKT : n;
				wait_go(pid, len[6:0]);
				tk(2, 0, 0, 0, HS_DATA);
				tk(3, 0, 0, 0, HS_NONE);
				pid = ~pid;
				n = n - len;
				if (len < MAX_PKT)
					break;
			end
			tk(1, 0, 1, 0, HS_ACK);
			reg_rd(8'h00, 32'h4);
		end
		$display("test read done");
		tk(0, 0, 0, su(8'h00, 8'h05, 16'h002a, 16'h0), HS_ACK);
		#1;
		chk("setup buffer released", 1, ctl_o.release_buf);
		reg_wr(8'h08, 32'h10000);
		wait_go(1'b1, 7'h0);
		tk(2, 0, 0, 0, HS_DATA);
		chk("old address", 0, dev_addr_o);
		tk(3, 0, 0, 0, HS_NONE);
		@(posedge ref_clk_i);
		#1;
		chk("new address", 7'h2a, dev_addr_o);
		reg_rd(8'h0c, 32'h2a);
		$display("test address done");
		tk(0, 0, 0, su(8'h40, 8'h01, 16'h0, 16'd10), HS_ACK);
		reg_wr(8'h08, 32'h10000);
		tk(1, 8, 1, 0, HS_ACK);
		#1;
		chk("out taken", 1, ctl_o.out_take);
		reg_wr(8'h04, 32'h7);
		tk(1, 2, 0, 0, HS_NAK);
		#1;
		chk("out refused", 0, ctl_o.out_take);
		reg_wr(8'h04, 32'h3);
		tk(1, 2, 0, 0, HS_ACK);
		wait_go(1'b1, 7'h0);
		tk(2, 0, 0, 0, HS_DATA);
		tk(3, 0, 0, 0, HS_NONE);
		reg_rd(8'h00, 32'h4);
		$display("test write done");
		for (int i = 0; i < 4; i++)
		begin
			if (i > 0)
			begin
				tk(0, 0, 0, su(b0s[i % 3], 8'h09, 16'h0, 16'h0), HS_NONE);
				#1;
				chk("leftover flushed", (i == 1) ? 1 : 0, ctl_o.flush);
			end
			tk(0, 0, 0, su(b0s[i % 3], 8'h09, 16'h0, (i == 2) ? 16'h0 : 16'h4), HS_ACK);
			if (i == 3)
				break;
			reg_wr(8'h08, 32'h0);
			if (i == 0)
				wait_go(1'b1, 7'h0);
			tk(2, 0, 0, 0, ans[i]);
			tk(1, 0, 1, 0, HS_STALL);
		end
		$display("test stall done");
		repeat (4) @(posedge ref_clk_i);
		chk("answers left", 0, hsq.size());
		host.set_reset(1'b1);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("irq on reset", 1, power_mgmt_irq_o);
		chk("address cleared", 10'h300, {ctl_o.dma_rst, ctl_o.pmm_rst, ep0_enable_o, dev_addr_o});
		repeat (HOLD) @(posedge ref_clk_i);
		chk("early again", 0, {ctl_o.sie_rst, ep0_enable_o});
		host.set_reset(1'b0);
		repeat (2) @(posedge ref_clk_i);
		#1;
		chk("recovery again", 2'b11, {ctl_o.sie_rst, ep0_enable_o});
		reg_rd(8'h00, 32'h5);
		$display("test second reset done");
		give_verdict();
	end
endmodule
